// *** logic/eptrk_defs.vh ***
// constants for the encoder position tracker
`ifndef EPTRK_DEFS_VH
`define EPTRK_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EPTRK_OFS_SPEED       8'h00
`define EPTRK_OFS_REV         8'h04
`define EPTRK_OFS_POS         8'h08
`define EPTRK_OFS_FINE        8'h0C
`define EPTRK_OFS_INHIBIT     8'h10
`define EPTRK_OFS_MARKER      8'h14
`define EPTRK_OFS_TURNS       8'h18
`define EPTRK_OFS_CONFIG      8'h1C
`define EPTRK_OFS_IRQ_STATUS  8'h20
`define EPTRK_OFS_IRQ_ENABLE  8'h24
`define EPTRK_OFS_IRQ_CLEAR   8'h28

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define EPTRK_CFG_TYPE_LSB    0
`define EPTRK_CFG_LINEAR_BIT  4
`define EPTRK_CFG_POLES_LSB   8
`define EPTRK_RST_TURNS       8'h10
`define EPTRK_RST_POLES       8'h02
`define EPTRK_RST_TYPE        4'h0
`define EPTRK_IRQ_MARKER      0
`define EPTRK_IRQ_DISPLAY     1
`define EPTRK_IRQ_ABSLOAD     2
`define EPTRK_TURNS_MAX       8'h10
`define EPTRK_RESP_OKAY       2'h0
`define EPTRK_RESP_SLVERR     2'h2

// ----------------------------------------
// encoder type codes
// ----------------------------------------
`define EPTRK_T_QUAD          4'h0
`define EPTRK_T_FREQ_DIR      4'h1
`define EPTRK_T_FWD_REV       4'h2
`define EPTRK_T_QUAD_COMM     4'h3
`define EPTRK_T_FD_COMM       4'h4
`define EPTRK_T_FR_COMM       4'h5
`define EPTRK_T_SINCOS        4'h6
`define EPTRK_T_SINCOS_COMM   4'h7
`define EPTRK_T_COMMS_A       4'h8
`define EPTRK_T_COMMS_B       4'h9
`define EPTRK_T_SSI           4'hA

// ----------------------------------------
// timing
// ----------------------------------------
`define EPTRK_CLK_NS          10
`define EPTRK_FAST_NS         250000
`define EPTRK_DISP_NS         4000000
`define EPTRK_FAST_CYC        (`EPTRK_FAST_NS / `EPTRK_CLK_NS)
`define EPTRK_DISP_CYC        (`EPTRK_DISP_NS / `EPTRK_CLK_NS)
`define EPTRK_DISP_MS         (`EPTRK_DISP_NS / 1000000)
// tenths of rpm per (1/2^32 rev per window), times 2^32
`define EPTRK_SPEED_SCALE     (600000 / `EPTRK_DISP_MS)
`define EPTRK_SPEED_LIMIT     400000

`endif

// *** logic/eptrk_turns.v ***
// revolution counter step with turns mask
`timescale 1ns/1ps
`include "eptrk_defs.vh"

module eptrk_turns (
	// current count and step
	input  wire [15:0] rev_in,
	input  wire        step_up,
	input  wire        step_down,
	// settings
	input  wire [7:0]  turns_bits,
	input  wire [3:0]  enc_type,
	input  wire        linear,
	// result
	output wire [15:0] rev_out,
	output wire [15:0] rev_mask
);

	function [15:0] turns_mask;
		input [7:0] tb;
		input [3:0] ty;
		input       lin;
		reg   [4:0] nb;
		begin
			nb = (tb > `EPTRK_TURNS_MAX) ? 5'h10 : tb[4:0];
			turns_mask = 16'hFFFF >> (5'h10 - nb);
			if (lin && ty >= `EPTRK_T_COMMS_A)
				turns_mask = 16'hFFFF;
		end
	endfunction

	wire [15:0] stepped;

	assign rev_mask = turns_mask(turns_bits, enc_type, linear);
	assign stepped  = step_up ? rev_in + 16'h0001 :
	                  step_down ? rev_in - 16'h0001 : rev_in;
	assign rev_out  = stepped & rev_mask;

endmodule

// *** logic/eptrk_speed.v ***
// filtered speed in tenths of rpm
`timescale 1ns/1ps
`include "eptrk_defs.vh"

module eptrk_speed (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// position movement
	input  wire        delta_valid,
	input  wire [31:0] delta,
	input  wire        clear,
	// window end
	input  wire        tick,
	// result
	output wire [31:0] speed
);

	reg  signed [39:0] acc_ff;
	reg  signed [31:0] speed_ff;
	wire signed [39:0] acc_now;
	wire signed [59:0] prod;
	wire signed [27:0] raw;
	wire signed [31:0] lim;
	wire signed [31:0] diff;

	assign acc_now = acc_ff + (delta_valid ? {{8{delta[31]}}, delta} : 40'sh0);
	assign prod    = acc_now * `EPTRK_SPEED_SCALE;
	assign raw     = prod[59:32];
	// clamp keeps a noisy window from wrapping the readout
	assign lim     = (raw > `EPTRK_SPEED_LIMIT) ? `EPTRK_SPEED_LIMIT :
	                 (raw < -`EPTRK_SPEED_LIMIT) ? -`EPTRK_SPEED_LIMIT :
	                 {{4{raw[27]}}, raw};
	assign diff    = lim - speed_ff;
	assign speed   = speed_ff;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff   <= 40'sh0;
			speed_ff <= 32'sh0;
		end else if (clear) begin
			acc_ff   <= 40'sh0;
			speed_ff <= 32'sh0;
		end else if (tick) begin
			acc_ff   <= 40'sh0;
			speed_ff <= speed_ff + (diff >>> 2);
		end else begin
			acc_ff   <= acc_now;
		end
	end

endmodule

// *** logic/eptrk_top.v ***
// encoder position tracker with axi4-lite registers
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eptrk_defs.vh"

module eptrk_top #(
	parameter FAST_CYC = `EPTRK_FAST_CYC,
	parameter DISP_CYC = `EPTRK_DISP_CYC
) (
	// clock and reset
	input  wire        CLK,
	input  wire        RST_N,
	// axi4-lite write
	input  wire [7:0]  AWADDR,
	input  wire        AWVALID,
	output wire        AWREADY,
	input  wire [31:0] WDATA,
	input  wire [3:0]  WSTRB,
	input  wire        WVALID,
	output wire        WREADY,
	output wire [1:0]  BRESP,
	output wire        BVALID,
	input  wire        BREADY,
	// axi4-lite read
	input  wire [7:0]  ARADDR,
	input  wire        ARVALID,
	output wire        ARREADY,
	output wire [31:0] RDATA,
	output wire [1:0]  RRESP,
	output wire        RVALID,
	input  wire        RREADY,
	// encoder front end
	input  wire        DELTA_VALID,
	input  wire [31:0] DELTA,
	input  wire        MARKER,
	input  wire        DIR_REV,
	input  wire        ABS_VALID,
	input  wire [47:0] ABS_POS,
	input  wire        AUTO_VALID,
	input  wire [7:0]  AUTO_TURNS,
	// outputs
	output wire [31:0] SIM_POS,
	output wire        IRQ
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	function marker_type;
		input [3:0] ty;
		begin
			marker_type = (ty <= `EPTRK_T_FR_COMM) || (ty == `EPTRK_T_SINCOS_COMM);
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg         awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	reg         aw_have_ff, w_have_ff;
	reg  [7:0]  aw_addr_ff;
	reg  [31:0] w_data_ff;
	reg  [3:0]  w_strb_ff;
	reg  [1:0]  bresp_ff, rresp_ff;
	reg  [31:0] rdata_ff;
	wire [31:0] speed_w;

	reg  [15:0] rev_ff;
	reg  [31:0] pos_ff;
	reg  [7:0]  pitch_ff;
	reg  [15:0] disp_rev_ff, disp_pos_ff, disp_fine_ff;
	reg  [31:0] sim_pos_ff;
	reg         inhibit_ff, inhibit_sh_ff;
	reg  [7:0]  turns_ff, turns_sh_ff;
	reg  [3:0]  type_ff;
	reg         linear_ff;
	reg  [7:0]  poles_ff;
	reg         marker_flag_ff, marker_d_ff;
	reg         abs_done_ff;
	reg  [2:0]  irq_status_ff, irq_enable_ff;
	reg         irq_ff;
	reg  [31:0] fast_cnt_ff, disp_cnt_ff;
	reg         fast_tick_ff, disp_tick_ff;

	// ----------------------------------------
	// axi write decode
	// ----------------------------------------
	wire        wr_go   = aw_have_ff && w_have_ff && !bvalid_ff;
	wire        wr_cfg  = wr_go && aw_addr_ff == `EPTRK_OFS_CONFIG;
	wire [31:0] cfg_old = {16'h0, poles_ff, 3'h0, linear_ff, type_ff};
	wire [31:0] cfg_new = merge(cfg_old, w_data_ff, w_strb_ff);
	wire        type_chg = wr_cfg && cfg_new[3:0] != type_ff;
	wire        wr_ok   = aw_addr_ff == `EPTRK_OFS_INHIBIT ||
	                      aw_addr_ff == `EPTRK_OFS_MARKER ||
	                      aw_addr_ff == `EPTRK_OFS_TURNS ||
	                      aw_addr_ff == `EPTRK_OFS_CONFIG ||
	                      aw_addr_ff == `EPTRK_OFS_IRQ_ENABLE ||
	                      aw_addr_ff == `EPTRK_OFS_IRQ_CLEAR;

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `EPTRK_RESP_OKAY;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h0;
			w_strb_ff  <= 4'h0;
		end else begin
			if (AWVALID && awready_ff) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= {AWADDR[7:2], 2'h0};
				awready_ff <= 1'b0;
			end
			if (WVALID && wready_ff) begin
				w_have_ff <= 1'b1;
				w_data_ff <= WDATA;
				w_strb_ff <= WSTRB;
				wready_ff <= 1'b0;
			end
			if (wr_go) begin
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_ok ? `EPTRK_RESP_OKAY : `EPTRK_RESP_SLVERR;
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
			end
			if (bvalid_ff && BREADY) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// axi read
	// ----------------------------------------
	reg  [31:0] rd_mux;
	reg         rd_ok;

	always @* begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case ({ARADDR[7:2], 2'h0})
		`EPTRK_OFS_SPEED:      rd_mux = speed_w;
		`EPTRK_OFS_REV:        rd_mux = {16'h0, disp_rev_ff};
		`EPTRK_OFS_POS:        rd_mux = {16'h0, disp_pos_ff};
		`EPTRK_OFS_FINE:       rd_mux = {16'h0, disp_fine_ff};
		`EPTRK_OFS_INHIBIT:    rd_mux = {31'h0, inhibit_sh_ff};
		`EPTRK_OFS_MARKER:     rd_mux = {31'h0, marker_flag_ff};
		`EPTRK_OFS_TURNS:      rd_mux = {24'h0, turns_sh_ff};
		`EPTRK_OFS_CONFIG:     rd_mux = cfg_old;
		`EPTRK_OFS_IRQ_STATUS: rd_mux = {29'h0, irq_status_ff};
		`EPTRK_OFS_IRQ_ENABLE: rd_mux = {29'h0, irq_enable_ff};
		`EPTRK_OFS_IRQ_CLEAR:  rd_mux = 32'h0;
		default:               rd_ok  = 1'b0;
		endcase
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0;
			rresp_ff   <= `EPTRK_RESP_OKAY;
		end else if (ARVALID && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_mux;
			rresp_ff   <= rd_ok ? `EPTRK_RESP_OKAY : `EPTRK_RESP_SLVERR;
		end else if (rvalid_ff && RREADY) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// update ticks
	// ----------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fast_cnt_ff  <= 32'h0;
			disp_cnt_ff  <= 32'h0;
			fast_tick_ff <= 1'b0;
			disp_tick_ff <= 1'b0;
		end else begin
			fast_tick_ff <= fast_cnt_ff == FAST_CYC - 1;
			fast_cnt_ff  <= (fast_cnt_ff == FAST_CYC - 1) ? 32'h0 : fast_cnt_ff + 32'h1;
			disp_tick_ff <= disp_cnt_ff == DISP_CYC - 1;
			disp_cnt_ff  <= (disp_cnt_ff == DISP_CYC - 1) ? 32'h0 : disp_cnt_ff + 32'h1;
		end
	end

	// ----------------------------------------
	// position tracking
	// ----------------------------------------
	wire [32:0] sum      = {1'b0, pos_ff} + {DELTA[31], DELTA};
	wire        carry    = DELTA_VALID && !DELTA[31] && sum[32];
	// a negative step that passes zero sets bit 32 of the sign-extended sum
	wire        borrow   = DELTA_VALID && DELTA[31] && sum[32];
	wire [7:0]  pairs    = (poles_ff[7:1] == 7'h0) ? 8'h01 : {1'b0, poles_ff[7:1]};
	// a linear pitch only becomes a revolution at the pitch counter's wrap
	wire        pitch_hi = pitch_ff == pairs - 8'h01;
	wire        rev_up   = carry && (!linear_ff || pitch_hi);
	wire        rev_dn   = borrow && (!linear_ff || pitch_ff == 8'h00);
	wire        mk_edge  = DIR_REV ? (marker_d_ff && !MARKER) : (!marker_d_ff && MARKER);
	wire        mk_hit   = mk_edge && marker_type(type_ff);
	wire        is_comms = type_ff >= `EPTRK_T_COMMS_A;
	wire        abs_go   = ABS_VALID && is_comms && !abs_done_ff;
	wire [47:0] abs_div  = (turns_ff == 8'h00) ? ABS_POS : ABS_POS / {40'h0, turns_ff};
	wire [47:0] abs_word = linear_ff ? {abs_div[31:0], 16'h0} : ABS_POS;
	wire [15:0] rev_next, rev_mask;

	eptrk_turns u_turns (
		.rev_in     (rev_ff),
		.step_up    (rev_up),
		.step_down  (rev_dn),
		.turns_bits (turns_ff),
		.enc_type   (type_ff),
		.linear     (linear_ff),
		.rev_out    (rev_next),
		.rev_mask   (rev_mask)
	);

	eptrk_speed u_speed (
		.clk         (CLK),
		.rst_n       (RST_N),
		.delta_valid (DELTA_VALID),
		.delta       (DELTA),
		.clear       (type_chg),
		.tick        (disp_tick_ff),
		.speed       (speed_w)
	);

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rev_ff      <= 16'h0;
			pos_ff      <= 32'h0;
			pitch_ff    <= 8'h00;
			abs_done_ff <= 1'b0;
			marker_d_ff <= 1'b0;
		end else begin
			marker_d_ff <= MARKER;
			if (type_chg) begin
				rev_ff      <= 16'h0;
				pos_ff      <= 32'h0;
				pitch_ff    <= 8'h00;
				abs_done_ff <= 1'b0;
			end else if (abs_go) begin
				rev_ff      <= abs_word[47:32] & rev_mask;
				pos_ff      <= abs_word[31:0];
				abs_done_ff <= 1'b1;
			end else begin
				rev_ff <= rev_next;
				if (mk_hit && !inhibit_ff)
					pos_ff <= 32'h0;
				else if (DELTA_VALID)
					pos_ff <= sum[31:0];
				if (linear_ff && carry)
					pitch_ff <= pitch_hi ? 8'h00 : pitch_ff + 8'h01;
				else if (linear_ff && borrow)
					pitch_ff <= (pitch_ff == 8'h00) ? pairs - 8'h01 : pitch_ff - 8'h01;
			end
		end
	end

	// ----------------------------------------
	// snapshots
	// ----------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sim_pos_ff   <= 32'h0;
			disp_rev_ff  <= 16'h0;
			disp_pos_ff  <= 16'h0;
			disp_fine_ff <= 16'h0;
		end else begin
			if (fast_tick_ff)
				sim_pos_ff <= pos_ff;
			if (disp_tick_ff) begin
				disp_rev_ff  <= rev_ff & rev_mask;
				disp_pos_ff  <= pos_ff[31:16];
				disp_fine_ff <= pos_ff[15:0];
			end
		end
	end

	// ----------------------------------------
	// settings
	// ----------------------------------------
	wire auto_ok = AUTO_VALID && (type_ff == `EPTRK_T_COMMS_A || type_ff == `EPTRK_T_COMMS_B);

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			inhibit_ff    <= 1'b0;
			inhibit_sh_ff <= 1'b0;
			turns_ff      <= `EPTRK_RST_TURNS;
			turns_sh_ff   <= `EPTRK_RST_TURNS;
			type_ff       <= `EPTRK_RST_TYPE;
			linear_ff     <= 1'b0;
			poles_ff      <= `EPTRK_RST_POLES;
			irq_enable_ff <= 3'h0;
		end else begin
			if (wr_go && aw_addr_ff == `EPTRK_OFS_INHIBIT && w_strb_ff[0])
				inhibit_sh_ff <= w_data_ff[0];
			if (auto_ok)
				turns_sh_ff <= AUTO_TURNS;
			else if (wr_go && aw_addr_ff == `EPTRK_OFS_TURNS && w_strb_ff[0])
				turns_sh_ff <= w_data_ff[7:0];
			// applied between updates so a half-done step never sees a new mask
			if (fast_tick_ff) begin
				inhibit_ff <= inhibit_sh_ff;
				turns_ff   <= turns_sh_ff;
			end
			if (wr_cfg) begin
				type_ff   <= cfg_new[3:0];
				linear_ff <= cfg_new[`EPTRK_CFG_LINEAR_BIT];
				poles_ff  <= cfg_new[15:8];
			end
			if (wr_go && aw_addr_ff == `EPTRK_OFS_IRQ_ENABLE && w_strb_ff[0])
				irq_enable_ff <= w_data_ff[2:0];
		end
	end

	// ----------------------------------------
	// marker flag and interrupts
	// ----------------------------------------
	wire       wr_flag = wr_go && aw_addr_ff == `EPTRK_OFS_MARKER && w_strb_ff[0];
	wire       wr_clr  = wr_go && aw_addr_ff == `EPTRK_OFS_IRQ_CLEAR && w_strb_ff[0];
	wire [2:0] ev      = {abs_go, disp_tick_ff, mk_hit};
	wire [2:0] nxt_irq_status = (irq_status_ff & ~(wr_clr ? w_data_ff[2:0] : 3'h0)) | ev;

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			marker_flag_ff <= 1'b0;
			irq_status_ff  <= 3'h0;
			irq_ff         <= 1'b0;
		end else begin
			if (mk_hit)
				marker_flag_ff <= 1'b1;
			else if (wr_flag)
				marker_flag_ff <= w_data_ff[0];
			irq_status_ff <= nxt_irq_status;
			irq_ff        <= |(nxt_irq_status & irq_enable_ff);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign AWREADY = awready_ff;
	assign WREADY  = wready_ff;
	assign BVALID  = bvalid_ff;
	assign BRESP   = bresp_ff;
	assign ARREADY = arready_ff;
	assign RVALID  = rvalid_ff;
	assign RDATA   = rdata_ff;
	assign RRESP   = rresp_ff;
	assign SIM_POS = sim_pos_ff;
	assign IRQ     = irq_ff;

endmodule

// *** bench/eptrk_props.sv ***
// assertion checker bound to the tracker top
`timescale 1ns/1ps
module eptrk_props #(
	parameter FAST_CYC = 25000,
	parameter DISP_CYC = 400000
) (
	// clock and reset
	input wire        CLK,
	input wire        RST_N,
	// register bus
	input wire [7:0]  ARADDR,
	input wire        ARVALID,
	input wire        ARREADY,
	input wire [31:0] RDATA,
	input wire [1:0]  RRESP,
	input wire        RVALID,
	input wire        RREADY,
	input wire        AWREADY,
	input wire        WREADY,
	input wire        BVALID,
	input wire        BREADY,
	// encoder output
	input wire [31:0] SIM_POS
);
	localparam int LIM = 400000;
	reg [7:0] ar_ff;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// ----------------------------------------
	// address of the read in flight
	// ----------------------------------------
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			ar_ff <= 8'h00;
		else if (ARVALID && ARREADY)
			ar_ff <= ARADDR;
	end

	property p_sim_hold;
		$changed(SIM_POS) |=> $stable(SIM_POS) [*7];
	endproperty
	a_sim_hold: assert property (p_sim_hold)
		else $error("simulated position refreshed twice in one period");
	property p_speed_span;
		RVALID && ar_ff == 8'h00 |-> $signed(RDATA) <= LIM && $signed(RDATA) >= -LIM;
	endproperty
	a_speed_span: assert property (p_speed_span)
		else $error("speed readout out of span");
	property p_rev_width;
		RVALID && ar_ff == 8'h04 |-> RDATA[31:16] == 16'h0000;
	endproperty
	a_rev_width: assert property (p_rev_width)
		else $error("revolution readout wider than 16 bits");
	property p_pos_width;
		RVALID && (ar_ff == 8'h08 || ar_ff == 8'h0C) |-> RDATA[31:16] == 16'h0000;
	endproperty
	a_pos_width: assert property (p_pos_width)
		else $error("position field wider than 16 bits");
	property p_ar_answer;
		ARVALID && ARREADY |=> RVALID && !ARREADY;
	endproperty
	a_ar_answer: assert property (p_ar_answer)
		else $error("read not answered on the next cycle");
	property p_r_release;
		RVALID && RREADY |=> !RVALID && ARREADY;
	endproperty
	a_r_release: assert property (p_r_release)
		else $error("read channel not released");
	property p_b_release;
		BVALID && BREADY |=> !BVALID && AWREADY && WREADY;
	endproperty
	a_b_release: assert property (p_b_release)
		else $error("write channel not released");
	property p_unmapped;
		ARVALID && ARREADY && ARADDR >= 8'h2C |=> RRESP == 2'h2 && RDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");
endmodule

bind eptrk_top eptrk_props #(
	.FAST_CYC(FAST_CYC),
	.DISP_CYC(DISP_CYC)
) chk_u (
	.CLK(CLK), .RST_N(RST_N), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
	.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .AWREADY(AWREADY),
	.WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .SIM_POS(SIM_POS)
);

// *** bench/eptrk_enc_model.sv ***
// encoder model: movement pulses, marker, absolute and turns data
`timescale 1ns/1ps
module eptrk_enc_model (
	// clock
	input  wire        clk,
	// movement and marker
	output reg         delta_valid,
	output reg  [31:0] delta,
	output reg         marker,
	output reg         dir_rev,
	// comms data
	output reg         abs_valid,
	output reg  [47:0] abs_pos,
	output reg         auto_valid,
	output reg  [7:0]  auto_turns
);
	initial begin
		delta_valid = 1'b0;
		delta = 32'h0;
		marker = 1'b0;
		dir_rev = 1'b0;
		abs_valid = 1'b0;
		abs_pos = 48'h0;
		auto_valid = 1'b0;
		auto_turns = 8'h00;
	end

	// back to back steps, each below one revolution
	task automatic move(input [31:0] d, input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				@(posedge clk);
				delta_valid <= 1'b1;
				delta <= d;
			end
			@(posedge clk);
			delta_valid <= 1'b0;
			delta <= ~d;
		end
	endtask

	// pulse high then low; only one of the two edges is active
	task automatic mark(input rev, input [31:0] d);
		begin
			@(posedge clk);
			dir_rev <= rev;
			@(posedge clk);
			marker <= 1'b1;
			move(d, 1);
			marker <= 1'b0;
			@(posedge clk);
		end
	endtask

	// absolute reading and turns count sent together
	task automatic sensor(input [47:0] p, input [7:0] t);
		begin
			@(posedge clk);
			abs_valid <= 1'b1;
			abs_pos <= p;
			auto_valid <= 1'b1;
			auto_turns <= t;
			@(posedge clk);
			abs_valid <= 1'b0;
			abs_pos <= ~p;
			auto_valid <= 1'b0;
			auto_turns <= ~t;
		end
	endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the encoder position tracker
`timescale 1ns/1ps
module tb_top;
	localparam int FC = 8;
	localparam int DC = 64;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [7:0]  awaddr = 8'h00;
	reg  [7:0]  araddr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg         awvalid = 1'b0;
	reg         wvalid = 1'b0;
	reg         bready = 1'b0;
	reg         arvalid = 1'b0;
	reg         rready = 1'b0;
	wire        awready, wready, bvalid, arready, rvalid, irq, dv, mk, dir, av, atv;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata, sim_pos, dlt;
	wire [47:0] abs_pos;
	wire [7:0]  auto_t;
	integer     n_mismatch = 0;
	integer     checks_done = 0;
	integer     t, i;
	reg         f;
	reg  [47:0] w;
	reg  [15:0] m;
	reg  [31:0] v;
	reg  [7:0]  tl [4] = '{8'h00, 8'h02, 8'h05, 8'h14};
	reg  [31:0] sd [2] = '{32'h01000000, 32'hFF000000};

	always #5 clk = ~clk;

	eptrk_top #(.FAST_CYC(FC), .DISP_CYC(DC)) dut_u (
		.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.DELTA_VALID(dv), .DELTA(dlt), .MARKER(mk), .DIR_REV(dir), .ABS_VALID(av),
		.ABS_POS(abs_pos), .AUTO_VALID(atv), .AUTO_TURNS(auto_t), .SIM_POS(sim_pos),
		.IRQ(irq)
	);
	eptrk_enc_model em_u (
		.clk(clk), .delta_valid(dv), .delta(dlt), .marker(mk), .dir_rev(dir),
		.abs_valid(av), .abs_pos(abs_pos), .auto_valid(atv), .auto_turns(auto_t)
	);

	// ----------------------------------------
	// comparison, verdict and bus tasks
	// ----------------------------------------
	task automatic chk(input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task automatic end_sim;
		begin
			$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task automatic tmo(input integer n);
		begin
			if (n >= 100) begin
				n_mismatch = n_mismatch + 1;
				end_sim;
			end
		end
	endtask
	function [31:0] rexp(input [7:0] a);
		rexp = (a >= 8'h2C) ? 32'h2 : 32'h0;
	endfunction
	task automatic wr(input [7:0] a, input [31:0] d);
		integer n;
		reg ad, wd;
		begin
			@(posedge clk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			ad = 1'b0;
			wd = 1'b0;
			n = 0;
			while (!(ad && wd) && n < 100) begin
				@(posedge clk);
				n = n + 1;
				if (!ad && awready === 1'b1) begin
					ad = 1'b1;
					awvalid <= 1'b0;
				end
				if (!wd && wready === 1'b1) begin
					wd = 1'b1;
					wvalid <= 1'b0;
				end
			end
			while (bvalid !== 1'b1 && n < 100) begin
				@(posedge clk);
				n = n + 1;
			end
			bready <= 1'b0;
			chk({30'h0, bresp}, rexp(a));
			tmo(n);
			// let status and interrupt updates land
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic rdv(input [7:0] a);
		integer n;
		begin
			@(posedge clk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			n = 0;
			@(posedge clk);
			while (arready !== 1'b1 && n < 100) begin
				@(posedge clk);
				n = n + 1;
			end
			arvalid <= 1'b0;
			@(posedge clk);
			while (rvalid !== 1'b1 && n < 100) begin
				@(posedge clk);
				n = n + 1;
			end
			rready <= 1'b0;
			v = rdata;
			chk({30'h0, rresp}, rexp(a));
			tmo(n);
		end
	endtask
	task automatic rd(input [7:0] a, input [31:0] exp);
		begin
			rdv(a);
			chk(v, exp);
		end
	endtask

	// ----------------------------------------
	// reference model of the tracked position
	// ----------------------------------------
	function [15:0] msk(input integer tu);
		reg [31:0] x;
		begin
			x = (32'h1 << ((tu > 16) ? 16 : tu)) - 32'h1;
			msk = x[15:0];
		end
	endfunction
	task automatic settle;
		repeat (DC + FC + 4) @(posedge clk);
	endtask
	task automatic mv(input [31:0] d, input integer n);
		begin
			em_u.move(d, n);
			repeat (n) w = w + {{16{d[31]}}, d};
		end
	endtask
	task automatic setup(input [3:0] ty, input [7:0] tu);
		begin
			wr(8'h18, {24'h0, tu});
			wr(8'h1C, {16'h0, 8'h02, 4'h0, (ty == 4'h0) ? 4'h1 : 4'h0});
			wr(8'h1C, {16'h0, 8'h02, 4'h0, ty});
			w = 48'h0;
			m = msk(tu);
			settle;
		end
	endtask
	task automatic chkpos;
		begin
			settle;
			rd(8'h04, {16'h0, w[47:32] & m});
			rd(8'h08, {16'h0, w[31:16]});
			rd(8'h0C, {16'h0, w[15:0]});
			chk(sim_pos, w[31:0]);
		end
	endtask

	initial begin
		void'($urandom(32'hF3C6));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h18, 32'h10);
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h1C, 32'h200);
		rd(8'h2C, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		foreach (tl[i]) begin
			mv($urandom, 3);
			setup(4'h0, tl[i]);
			chkpos;
			mv(32'hC0000000, 6);
			chkpos;
			repeat (3) begin
				mv($urandom, 1 + $urandom % 8);
				chkpos;
			end
		end
		for (t = 0; t <= 10; t = t + 1) begin
			setup(t[3:0], 8'h10);
			mv(32'h30000000, 2);
			wr(8'h14, 32'h0);
			wr(8'h28, 32'h7);
			wr(8'h24, 32'h1);
			f = (t != 6 && t < 8);
			em_u.mark(1'b0, 32'h00100000);
			w = f ? {w[47:32], 32'h00100000} : w + 48'h100000;
			chk({31'h0, irq}, {31'h0, f});
			chkpos;
			rd(8'h14, {31'h0, f});
		end
		setup(4'h0, 8'h10);
		mv(32'h50000000, 3);
		em_u.mark(1'b1, 32'h00100000);
		w = {w[47:32], 32'h0};
		chkpos;
		wr(8'h10, 32'h1);
		settle;
		em_u.mark(1'b0, 32'h00100000);
		w = w + 48'h100000;
		chkpos;
		rd(8'h14, 32'h1);
		settle;
		rd(8'h14, 32'h1);
		wr(8'h24, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h24, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(8'h28, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rd(8'h28, 32'h0);
		setup(4'h8, 8'h10);
		v = $urandom;
		w = {v[15:0], $urandom};
		em_u.sensor(w, 8'h03);
		m = msk(3);
		chkpos;
		rd(8'h18, 32'h3);
		// linear incremental, four poles: two pitches make one turn
		setup(4'h0, 8'h10);
		wr(8'h1C, 32'h00000411);
		mv(32'h40000000, 12);
		w[47:32] = w[47:32] >> 1;
		chkpos;
		// linear comms: reading divided by the ratio, turns unmasked
		setup(4'h0, 8'h04);
		wr(8'h1C, 32'h00000218);
		v = $urandom;
		w = {v[15:0], $urandom};
		em_u.sensor(w, 8'h04);
		w = w / 48'h4;
		w = {w[31:0], 16'h0};
		m = 16'hFFFF;
		chkpos;
		rd(8'h04, {16'h0, w[47:32]});
		setup(4'h0, 8'h10);
		foreach (sd[i]) begin
			em_u.move(sd[i], 4 * DC);
			rdv(8'h00);
			chk({31'h0, $signed(v) > 0}, {31'h0, i == 0});
		end
		end_sim;
	end
endmodule
